// File: hdl/uart_baud_rate_generator.sv
// Bit rate tick generator for the four-mode serial port
// Functional notes
// - Mode 0 gives one bit per 12 core clocks, ignoring timers and doubling.
// - Mode 2 gives one bit per 64 core clocks, or per 32 when doubled.
// - Modes 1 and 3 time bits from Timer 1 or Timer 2, per direction.
// - From Timer 1 a bit takes 32 overflows, or 16 when doubled.
// - Any Timer 1 overflow pulse is accepted, whatever the timer's mode.
// - With 8-bit reload the rate is 2^dbl/32 * core/(12*(256-reload)).
// - From Timer 2 a bit takes 16 overflows.
// - In rate mode Timer 2 steps once every two core clocks.
// - Either clock select bit puts Timer 2 in rate mode for its direction.
// - From Timer 2 the rate is core/(32*(65536-reload)).
// - Each Timer 2 overflow reloads the 16-bit capture value.
// - Mode 0, mode 2 and Timer 2 rates are counted in core clocks set by the core divider bits; Timer 1 pulses are not.
`timescale 1ns/1ps
`include "ubg_regs.svh"
module uart_baud_rate_generator
   import ubg_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  serialMode,
   input  wire logic        baudDoubleBit,
   input  wire logic [2:0]  coreDividerBits,
   input  wire logic        txClockSelect,
   input  wire logic        rxClockSelect,
   input  wire logic        timer1Overflow,
   input  wire logic [7:0]  reloadCaptureHigh,
   input  wire logic [7:0]  reloadCaptureLow,
   output logic             txTick,
   output logic             rxTick,
   output logic             timer2Overflow,
   output logic [15:0]      timer2Count
);
   // ---------------------------------------------------------------
   // Core clock enable
   // ---------------------------------------------------------------
   ubg_div_type coreCnt_r;
   ubg_div_type coreCnt_nxt;
   ubg_div_type coreMask;
   logic        coreEn;

   // Free counter; low bits all ones marks one core clock of 2^cd
   always_comb begin
      coreMask    = (`UBG_CORE_MASK_ONE << coreDividerBits)
                    - `UBG_CORE_MASK_ONE;
      coreEn      = ((coreCnt_r & coreMask) == coreMask);
      coreCnt_nxt = coreCnt_r + `UBG_CORE_CNT_ONE;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         coreCnt_r <= `UBG_CORE_CNT_RESET;
      end else begin
         coreCnt_r <= coreCnt_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Timer 2 in rate generator mode
   // ---------------------------------------------------------------
   logic       t2Run;
   logic       t2Inc;
   logic       t2Ovf;
   logic       t2Phase_r;
   logic       t2Phase_nxt;
   ubg_t2_type t2Count_r;
   ubg_t2_type t2Count_nxt;
   logic       t2Ovf_r;

   // Phase bit halves the core rate instead of the 12-clock cycle
   always_comb begin
      t2Run       = txClockSelect | rxClockSelect;
      t2Inc       = t2Run & coreEn & t2Phase_r;
      t2Ovf       = t2Inc & (t2Count_r == `UBG_T2_MAX);
      t2Phase_nxt = t2Phase_r;
      t2Count_nxt = t2Count_r;
      if (t2Run && coreEn) begin
         t2Phase_nxt = ~t2Phase_r;
      end
      if (t2Ovf) begin
         t2Count_nxt = {reloadCaptureHigh, reloadCaptureLow};
      end else if (t2Inc) begin
         t2Count_nxt = t2Count_r + `UBG_T2_ONE;
      end
   end

   // Parked at the top count, so no 65536-step crawl before the first reload
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         t2Phase_r <= 1'b0;
         t2Count_r <= `UBG_T2_RESET;
         t2Ovf_r   <= 1'b0;
      end else begin
         t2Phase_r <= t2Phase_nxt;
         t2Count_r <= t2Count_nxt;
         t2Ovf_r   <= t2Ovf;
      end
   end

   // ---------------------------------------------------------------
   // Per-direction source and ratio
   // ---------------------------------------------------------------
   function automatic ubg_div_type dirLimit(
      input logic [1:0] m,
      input logic       dbl,
      input logic       useT2
   );
      ubg_div_type lim;
      lim = `UBG_MODE0_DIV;
      case (m)
         UBG_SHIFT8:    lim = `UBG_MODE0_DIV;
         UBG_UART9_FIX: lim = dbl ? `UBG_MODE2_DIV_X2
                                  : `UBG_MODE2_DIV;
         UBG_UART8_VAR,
         UBG_UART9_VAR: begin
            if (useT2) begin
               lim = `UBG_T2_PER_BIT;
            end else begin
               lim = dbl ? `UBG_T1_PER_BIT_X2
                         : `UBG_T1_PER_BIT;
            end
         end
         default:       lim = `UBG_MODE0_DIV;
      endcase
      return lim;
   endfunction

   function automatic logic dirSrc(
      input logic [1:0] m,
      input logic       coreE,
      input logic       t1O,
      input logic       t2O,
      input logic       useT2
   );
      logic s;
      s = coreE;
      if (m[0]) begin
         // Timer 1 pulse taken as is, its own mode is not examined
         s = useT2 ? t2O : t1O;
      end
      return s;
   endfunction

   ubg_div_type txLimit;
   ubg_div_type rxLimit;
   logic        txSrc;
   logic        rxSrc;
   logic        txHit;
   logic        rxHit;

   // Transmit and receive choose their timer independently
   always_comb begin
      txLimit = dirLimit(serialMode, baudDoubleBit, txClockSelect);
      rxLimit = dirLimit(serialMode, baudDoubleBit, rxClockSelect);
      txSrc   = dirSrc(serialMode, coreEn, timer1Overflow, t2Ovf,
                       txClockSelect);
      rxSrc   = dirSrc(serialMode, coreEn, timer1Overflow, t2Ovf,
                       rxClockSelect);
   end

   ubg_tick_div u_txDiv (
      .mclk  (mclk),
      .rst_n (rst_n),
      .srcEn (txSrc),
      .limit (txLimit),
      .hit   (txHit)
   );

   ubg_tick_div u_rxDiv (
      .mclk  (mclk),
      .rst_n (rst_n),
      .srcEn (rxSrc),
      .limit (rxLimit),
      .hit   (rxHit)
   );

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   logic txTick_r;
   logic rxTick_r;

   // Ticks registered so the shift logic sees clean one-cycle pulses
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         txTick_r <= 1'b0;
         rxTick_r <= 1'b0;
      end else begin
         txTick_r <= txHit;
         rxTick_r <= rxHit;
      end
   end

   assign txTick         = txTick_r;
   assign rxTick         = rxTick_r;
   assign timer2Overflow = t2Ovf_r;
   assign timer2Count    = t2Count_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   logic [1:0] modeQ_r;
   logic       cfgStable;

   // Serial mode held over the last cycle
   always_ff @(posedge mclk) begin
      modeQ_r <= serialMode;
   end

   assign cfgStable = (modeQ_r == serialMode);

   a_mode0_ratio: assert property (@(posedge mclk) disable iff (!rst_n)
      (serialMode == UBG_SHIFT8) |->
      (txLimit == `UBG_MODE0_DIV && txSrc == coreEn))
      else $error("mode 0 ratio wrong");

   a_mode2_ratio: assert property (@(posedge mclk) disable iff (!rst_n)
      (serialMode == UBG_UART9_FIX) |->
      (rxLimit == (baudDoubleBit ? `UBG_MODE2_DIV_X2 : `UBG_MODE2_DIV)))
      else $error("mode 2 ratio wrong");

   a_t1_source: assert property (@(posedge mclk) disable iff (!rst_n)
      (txTick_r && $past(serialMode[0]) && !$past(txClockSelect))
      |-> $past(timer1Overflow))
      else $error("tx tick without timer 1 overflow");

   a_t1_ratio: assert property (@(posedge mclk) disable iff (!rst_n)
      (serialMode[0] && !rxClockSelect) |->
      (rxLimit == (baudDoubleBit ? `UBG_T1_PER_BIT_X2 : `UBG_T1_PER_BIT)))
      else $error("timer 1 ratio wrong");

   a_t2_source: assert property (@(posedge mclk) disable iff (!rst_n)
      (rxTick_r && $past(serialMode[0]) && $past(rxClockSelect)
       && cfgStable) |-> $past(t2Ovf))
      else $error("rx tick without timer 2 overflow");

   a_t2_reload: assert property (@(posedge mclk) disable iff (!rst_n)
      t2Ovf |=> (timer2Count == $past({reloadCaptureHigh,
                                        reloadCaptureLow})))
      else $error("timer 2 reload missed");

   a_t2_halfrate: assert property (@(posedge mclk) disable iff (!rst_n)
      t2Inc |=> !t2Inc)
      else $error("timer 2 stepped twice in a row");

   a_t2_idle: assert property (@(posedge mclk) disable iff (!rst_n)
      (!txClockSelect && !rxClockSelect) |=> $stable(timer2Count))
      else $error("timer 2 ran without select");

   a_core_div: assert property (@(posedge mclk) disable iff (!rst_n)
      (coreEn && coreDividerBits == 3'h1) ##1 (coreDividerBits == 3'h1)
      |-> !coreEn)
      else $error("core enable too fast");

   a_tick_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
      txTick |=> !txTick)
      else $error("tx tick longer than one cycle");

   c_mode0_tick: cover property (@(posedge mclk) disable iff (!rst_n)
      serialMode == 2'h0 && txTick);
   c_mode2_dbl: cover property (@(posedge mclk) disable iff (!rst_n)
      serialMode == 2'h2 && baudDoubleBit && rxTick);
   c_split_src: cover property (@(posedge mclk) disable iff (!rst_n)
      serialMode[0] && txClockSelect && !rxClockSelect && rxTick);
   c_t2_reload: cover property (@(posedge mclk) disable iff (!rst_n)
      t2Ovf);
endmodule // uart_baud_rate_generator

// File: hdl/ubg_tick_div.sv
// Pulse divider: one hit per limit source enables
`timescale 1ns/1ps
`include "ubg_regs.svh"
module ubg_tick_div
   import ubg_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        srcEn,
   input  wire ubg_div_type limit,
   output logic             hit
);
   ubg_div_type cnt_r;
   ubg_div_type cnt_nxt;

   // Compare with >= so a smaller new limit never strands the count
   always_comb begin
      cnt_nxt = cnt_r;
      hit     = 1'b0;
      if (srcEn) begin
         if (cnt_r >= limit - `UBG_DIV_ONE) begin
            hit     = 1'b1;
            cnt_nxt = `UBG_DIV_ZERO;
         end else begin
            cnt_nxt = cnt_r + `UBG_DIV_ONE;
         end
      end
   end

   // Count register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt_r <= `UBG_DIV_ZERO;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule // ubg_tick_div

// File: shared/ubg_pkg.sv
// Types shared by the serial bit rate generator
package ubg_pkg;
   typedef enum logic [1:0] {
      UBG_SHIFT8    = 2'h0,
      UBG_UART8_VAR = 2'h1,
      UBG_UART9_VAR = 2'h3,
      UBG_UART9_FIX = 2'h2
   } ubg_mode_type;

   typedef logic [6:0]  ubg_div_type;
   typedef logic [15:0] ubg_t2_type;
endpackage

// File: shared/ubg_regs.svh
// Named constants for the serial bit rate generator
`ifndef UBG_REGS_SVH
`define UBG_REGS_SVH

// ------------------------------------------------------------------
// Division ratios, counted in source enable pulses
// ------------------------------------------------------------------
`define UBG_MODE0_DIV       7'h0C
`define UBG_MODE2_DIV       7'h40
`define UBG_MODE2_DIV_X2    7'h20
`define UBG_T1_PER_BIT      7'h20
`define UBG_T1_PER_BIT_X2   7'h10
`define UBG_T2_PER_BIT      7'h10
`define UBG_DIV_ONE         7'h01
`define UBG_DIV_ZERO        7'h00

// ------------------------------------------------------------------
// Timer 2 and core divider
// ------------------------------------------------------------------
`define UBG_T2_MAX          16'hFFFF
`define UBG_T2_ONE          16'h0001
// Timer 2 leaves reset at its top count, so its first step loads the reload
`define UBG_T2_RESET        16'hFFFF
`define UBG_CORE_MASK_ONE   7'h01
`define UBG_CORE_CNT_ONE    7'h01
`define UBG_CORE_CNT_RESET  7'h00

`endif

// File: tb/uart_baud_rate_generator_tb.sv
// Self-checking bench for the serial bit rate generator
`timescale 1ns/1ps
`include "ubg_regs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
   fails++; $display("wrong value %s exp %0d got %0d", nm, e, g); end end
module uart_baud_rate_generator_tb
   import ubg_pkg::*;
;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic [1:0]  serialMode = 2'h0;
   logic        baudDoubleBit = 1'b0;
   logic [2:0]  coreDividerBits = 3'h0;
   logic        txClockSelect = 1'b0;
   logic        rxClockSelect = 1'b1;
   logic [7:0]  reloadCaptureHigh = 8'hFF;
   logic [7:0]  reloadCaptureLow = 8'hFF;
   logic [3:0]  t1Period = 4'h4;
   logic        timer1Overflow, txTick, rxTick, timer2Overflow;
   logic [15:0] timer2Count, held;
   logic [31:0] r = 32'h00017D38;
   int          gap [3];
   int          n [3];
   int          fails = 0;
   int          checks_done = 0;
   int          i, p, e, rl;

   uart_baud_rate_generator i_uart_baud_rate_generator (.mclk(mclk),
      .rst_n(rst_n), .serialMode(serialMode), .baudDoubleBit(baudDoubleBit),
      .coreDividerBits(coreDividerBits), .txClockSelect(txClockSelect),
      .rxClockSelect(rxClockSelect), .timer1Overflow(timer1Overflow),
      .reloadCaptureHigh(reloadCaptureHigh),
      .reloadCaptureLow(reloadCaptureLow), .txTick(txTick), .rxTick(rxTick),
      .timer2Overflow(timer2Overflow), .timer2Count(timer2Count));
   ubg_serial_partner i_ubg_serial_partner (.mclk(mclk), .rst_n(rst_n),
      .t1Period(t1Period), .events({timer2Overflow, rxTick, txTick}),
      .timer1Overflow(timer1Overflow), .gap(gap), .n(n));

   // 100 MHz clock
   always #5 mclk = ~mclk;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Clocks per bit for core-timed modes and for Timer 1 pacing
   function automatic int expGap(input int m, input int d, input int cd,
                                 input int t1);
      if (m == 0) return 12 << cd;
      if (m == 2) return (d ? 32 : 64) << cd;
      return t1 * (d ? 16 : 32);
   endfunction

   // First gap after a change may be partial, so judge the third
   task automatic gapChk(input int k, input int e, input string nm);
      int n0, c;
      n0 = n[k];
      c = 0;
      while (n[k] < n0 + 3 && c < 40000) begin
         @(negedge mclk);
         c++;
      end
      if (c >= 40000) fails++;
      `CHK(nm, e, gap[k])
   endtask

   task automatic stop_test;
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog well above the roughly 12k cycles the sequence needs
   initial begin
      repeat (60000) @(posedge mclk);
      fails++;
      stop_test();
   end

   // Main sequence
   initial begin
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      // All four modes with both doubling values, random divider and T1 rate
      for (i = 0; i < 8; i++) begin
         r = lfsr(r);
         p = (i == 0) ? 7 : int'(r[0]);
         @(posedge mclk);
         serialMode <= 2'(i / 2);
         baudDoubleBit <= i[0];
         coreDividerBits <= 3'(p);
         t1Period <= 4'h3 + {2'h0, r[2:1]};
         e = expGap(i / 2, i % 2, p, 3 + int'(r[2:1]));
         gapChk(0, e, "txTick");
         if (!i[1]) gapChk(1, e, "rxTick");
      end
      // New reload value: wait for one overflow before timing Timer 2
      r = lfsr(r);
      rl = 16 - int'(r[3:0]);
      @(posedge mclk);
      coreDividerBits <= 3'h0;
      reloadCaptureLow <= {4'hF, r[3:0]};
      e = 0;
      while (timer2Overflow !== 1'b1 && e < 2000) begin
         @(negedge mclk);
         e++;
      end
      if (e >= 2000) fails++;
      @(posedge mclk);
      serialMode <= {r[4], 1'b1};
      baudDoubleBit <= r[5];
      txClockSelect <= 1'b1;
      gapChk(2, 2 * rl, "timer2Overflow");
      gapChk(1, 32 * rl, "rxTick");
      gapChk(0, 32 * rl, "txTick");
      @(negedge mclk);
      while (timer2Overflow !== 1'b1) @(negedge mclk);
      `CHK("timer2Count", {8'hFF, 4'hF, r[3:0]}, timer2Count)
      // Mixed sources: transmit from Timer 1, receive from Timer 2
      @(posedge mclk);
      txClockSelect <= 1'b0;
      t1Period <= 4'h5;
      gapChk(0, expGap(1, int'(r[5]), 0, 5), "txTick");
      gapChk(1, 32 * rl, "rxTick");
      // With no select bit Timer 2 stands still
      @(posedge mclk);
      rxClockSelect <= 1'b0;
      repeat (2) @(negedge mclk);
      held = timer2Count;
      repeat (10) @(negedge mclk);
      `CHK("timer2Count", held, timer2Count)
      // Reset in mid-run quiets every output, then mode 0 restarts cleanly
      @(posedge mclk);
      rst_n <= 1'b0;
      serialMode <= UBG_SHIFT8;
      repeat (2) @(negedge mclk);
      `CHK("reset", 3'h0, {txTick, rxTick, timer2Overflow})
      `CHK("reset count", `UBG_T2_RESET, timer2Count)
      // First tick after release lands on the twelfth core enable
      @(posedge mclk);
      rst_n <= 1'b1;
      repeat (11) @(posedge mclk);
      @(negedge mclk);
      `CHK("txTick early", 1'b0, txTick)
      @(negedge mclk);
      `CHK("first ticks", 2'h3, {txTick, rxTick})
      stop_test();
   end
endmodule // uart_baud_rate_generator_tb

// File: tb/ubg_serial_partner.sv
// Far-side model: Timer 1 pulse source and shift-logic tick monitor
`timescale 1ns/1ps
module ubg_serial_partner
   import ubg_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [3:0] t1Period,
   input  wire logic [2:0] events,
   output logic            timer1Overflow,
   output int              gap [3],
   output int              n [3]
);
   int         cyc;
   int         last [3];
   logic [3:0] t1Cnt;

   // Timer 1 overflow every t1Period clocks; its interrupt stays unused
   // Only pulse spacing matters, so any Timer 1 mode looks alike
   always @(posedge mclk) begin
      if (!rst_n) begin
         t1Cnt <= 4'h0;
         timer1Overflow <= 1'b0;
      end else begin
         t1Cnt <= (t1Cnt >= t1Period - 4'h1) ? 4'h0 : t1Cnt + 4'h1;
         timer1Overflow <= (t1Cnt >= t1Period - 4'h1);
      end
   end

   // Shift logic consumes each tick; spacing kept to judge the bit rate
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      for (int k = 0; k < 3; k++) begin
         if (!rst_n) begin
            n[k] <= 0;
            last[k] <= cyc;
         end else if (events[k]) begin
            gap[k] <= cyc - last[k];
            last[k] <= cyc;
            n[k] <= n[k] + 1;
         end
      end
   end
endmodule // ubg_serial_partner
